// File: core/stm_output_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module stm_output_ctrl import stm_pkg::*; (
  input  wire logic         clk,             // core clock, 125 MHz
  input  wire logic         rst_n,           // async reset, active low
  input  wire stm_bus_req_t bus_req,         // register strobes, address, data
  output logic [DAT_W-1:0]  rdata,           // read data, cycle after read
  input  wire logic         tmr_clk_pin,     // external timer clock pin
  output logic              timer_out_pin_a, // timer output pin a
  output logic              timer_out_pin_b, // timer output pin b
  output logic              irq              // level interrupt
);
  stm_core_t       st_ff;
  stm_core_t       nxt_st;
  logic            tick;
  logic            run_rise;
  logic            a_hit;
  logic            p_hit;
  logic            clr_hit;
  logic            duty_act;
  logic            drive;
  logic [EV_W-1:0] ev;
  stm_mode_t       mode;

  // timer clock edges from the pin
  stm_pin_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in (tmr_clk_pin),
    .tick   (tick)
  );

  // comparator events and run edge
  assign mode     = stm_mode_t'(st_ff.c1.mode);
  assign run_rise = st_ff.c0.run & ~st_ff.run_prev;
  assign a_hit    = tick & st_ff.c0.run & (st_ff.cnt == st_ff.compare_a_value);
  // period match at the last count of the slot; zero wraps to overflow
  assign p_hit    = tick & st_ff.c0.run
                  & (st_ff.cnt[CNT_W-1:PRD_LSB] == st_ff.c0.prd - PRD_ONE)
                  & (st_ff.cnt[PRD_LSB-1:0] == LOW_ALL);
  assign ev       = {p_hit, a_hit};

  // pick the clearing comparator for the active mode
  always_comb begin
    case (mode)
      MODE_PWM: clr_hit = st_ff.c1.dpx ? a_hit : p_hit;
      MODE_CAP: clr_hit = p_hit;
      default:  clr_hit = st_ff.c1.cclr ? a_hit : p_hit;
    endcase
  end

  // duty window; swap makes the period comparator hold the duty
  assign duty_act = st_ff.c1.dpx ? (st_ff.cnt[CNT_W-1:PRD_LSB] < st_ff.c0.prd)
                                 : (st_ff.cnt < st_ff.compare_a_value);

  // pin driven only in compare and pwm modes
  assign drive = (mode == MODE_CMP) || (mode == MODE_PWM);

  // next state: bus, counter, output level, status
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.run_prev = st_ff.c0.run;
    nxt_st.rdata    = DAT_ZERO;
    // counter: run edge zeroes, stopped run holds
    if (run_rise) begin
      nxt_st.cnt = CNT_ZERO;
    end else if (tick && st_ff.c0.run) begin
      nxt_st.cnt = clr_hit ? CNT_ZERO : st_ff.cnt + CNT_ONE;
    end
    // logical output level before polarity
    case (mode)
      MODE_CMP: begin
        if (run_rise) begin
          nxt_st.out = st_ff.c1.oc;
        end else if (a_hit) begin
          case (st_ff.c1.io)
            IO_LOW:  nxt_st.out = 1'b0;
            IO_HIGH: nxt_st.out = 1'b1;
            IO_TOGL: nxt_st.out = ~st_ff.out;
            default: nxt_st.out = st_ff.out;
          endcase
        end
      end
      MODE_PWM: begin
        // single pulse: active from run edge to the compare A match
        if (run_rise) begin
          nxt_st.sp_act = 1'b1;
        end else if (!st_ff.c0.run || a_hit) begin
          nxt_st.sp_act = 1'b0;
        end
        case (st_ff.c1.io)
          IO_INACT:  nxt_st.out = ~st_ff.c1.oc;
          IO_ACT:    nxt_st.out = st_ff.c1.oc;
          IO_PWM:    nxt_st.out = duty_act ? st_ff.c1.oc : ~st_ff.c1.oc;
          IO_SINGLE: nxt_st.out = st_ff.sp_act ? st_ff.c1.oc : ~st_ff.c1.oc;
          default:   nxt_st.out = st_ff.out;
        endcase
      end
      default: begin
        nxt_st.out = 1'b0;
      end
    endcase
    // sticky events, set wins over write-one-clear
    nxt_st.sts = st_ff.sts | ev;
    if (bus_req.wr) begin
      case (bus_req.addr)
        ADR_CTL0: begin
          nxt_st.c0     = bus_req.wdata;
          nxt_st.c0.pad = '0;
        end
        ADR_CTL1:  nxt_st.c1 = bus_req.wdata;
        ADR_CCA_L: nxt_st.compare_a_value[DAT_W-1:0] = bus_req.wdata;
        ADR_CCA_H: nxt_st.compare_a_value[CNT_W-1:DAT_W] = bus_req.wdata[HI_W-1:0];
        ADR_STS:   nxt_st.sts = (st_ff.sts & ~bus_req.wdata[EV_W-1:0]) | ev;
        ADR_MSK:   nxt_st.msk = bus_req.wdata[EV_W-1:0];
        default:   nxt_st.msk = st_ff.msk;
      endcase
    end
    // read mux; unmapped and reserved bits read zero
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADR_CTL0:  nxt_st.rdata = st_ff.c0;
        ADR_CTL1:  nxt_st.rdata = st_ff.c1;
        ADR_CNT_L: nxt_st.rdata = st_ff.cnt[DAT_W-1:0];
        ADR_CNT_H: nxt_st.rdata = {HI_PAD, st_ff.cnt[CNT_W-1:DAT_W]};
        ADR_CCA_L: nxt_st.rdata = st_ff.compare_a_value[DAT_W-1:0];
        ADR_CCA_H: nxt_st.rdata = {HI_PAD, st_ff.compare_a_value[CNT_W-1:DAT_W]};
        ADR_STS:   nxt_st.rdata = {{(DAT_W-EV_W){1'b0}}, st_ff.sts};
        ADR_MSK:   nxt_st.rdata = {{(DAT_W-EV_W){1'b0}}, st_ff.msk};
        default:   nxt_st.rdata = DAT_ZERO;
      endcase
    end
    // pin follows next level, invert and mode
    nxt_st.pin = drive && (nxt_st.c1.mode == MODE_CMP || nxt_st.c1.mode == MODE_PWM)
               ? nxt_st.out ^ nxt_st.c1.pol : 1'b0;
    if (!(nxt_st.c1.mode == MODE_CMP || nxt_st.c1.mode == MODE_PWM)) begin
      nxt_st.pin = 1'b0;
    end else begin
      nxt_st.pin = nxt_st.out ^ nxt_st.c1.pol;
    end
    nxt_st.irq = |(nxt_st.sts & nxt_st.msk);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata           = st_ff.rdata;
  assign timer_out_pin_a = st_ff.pin;
  assign timer_out_pin_b = st_ff.pin;
  assign irq             = st_ff.irq;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic cmp_now;
  assign cmp_now = (mode == MODE_CMP) && !run_rise;

  chk_cmp_high_act: assert property (
    cmp_now && a_hit && st_ff.c1.io == IO_HIGH |=> st_ff.out)
    else $error("compare high action not taken");
  chk_cmp_low_act: assert property (
    cmp_now && a_hit && st_ff.c1.io == IO_LOW |=> !st_ff.out)
    else $error("compare low action not taken");
  chk_cmp_no_change: assert property (
    cmp_now && st_ff.c1.io == IO_NONE |=> st_ff.out == $past(st_ff.out))
    else $error("output changed with no action");
  chk_run_init_lvl: assert property (
    (mode == MODE_CMP) && run_rise |=> st_ff.out == $past(st_ff.c1.oc))
    else $error("run edge did not restore initial level");
  chk_tmr_pin_idle: assert property (
    st_ff.c1.mode == MODE_TMR |-> !timer_out_pin_a && !timer_out_pin_b)
    else $error("pin driven in timer mode");
  chk_pin_polarity: assert property (
    st_ff.c1.mode == MODE_CMP |-> timer_out_pin_a == (st_ff.out ^ st_ff.c1.pol))
    else $error("pin polarity wrong");
  chk_clr_on_a: assert property (
    (mode == MODE_CMP || mode == MODE_TMR) && !run_rise && st_ff.c1.cclr && a_hit
    |=> st_ff.cnt == CNT_ZERO)
    else $error("counter not cleared on A match");
  chk_clr_on_p: assert property (
    (mode == MODE_CMP) && !run_rise && !st_ff.c1.cclr && p_hit
    |=> st_ff.cnt == CNT_ZERO)
    else $error("counter not cleared on period match");
  chk_swap_period: assert property (
    (mode == MODE_PWM) && !run_rise && st_ff.c1.dpx && a_hit |=> st_ff.cnt == CNT_ZERO)
    else $error("swapped period not from A");
  chk_run_zero: assert property (
    run_rise |=> st_ff.cnt == CNT_ZERO)
    else $error("run edge did not zero counter");
  chk_hi_byte_read: assert property (
    bus_req.rd && bus_req.addr == ADR_CNT_H
    |=> rdata == {HI_PAD, $past(st_ff.cnt[CNT_W-1:DAT_W])})
    else $error("counter high byte wrong");
  chk_hold_stopped: assert property (
    !st_ff.c0.run && !(bus_req.wr && bus_req.addr == ADR_CTL0)
    |=> st_ff.cnt == $past(st_ff.cnt))
    else $error("stopped counter moved");

  // output actions in compare and pwm modes, idle pins in capture mode
  chk_cmp_toggle: assert property (
    cmp_now && a_hit && st_ff.c1.io == IO_TOGL |=> st_ff.out != $past(st_ff.out))
    else $error("compare toggle action not taken");
  chk_pwm_force_act: assert property (
    (mode == MODE_PWM) && st_ff.c1.io == IO_ACT |=> st_ff.out == $past(st_ff.c1.oc))
    else $error("forced active level wrong");
  chk_pwm_force_inact: assert property (
    (mode == MODE_PWM) && st_ff.c1.io == IO_INACT |=> st_ff.out != $past(st_ff.c1.oc))
    else $error("forced inactive level wrong");
  chk_pwm_duty_win: assert property (
    (mode == MODE_PWM) && st_ff.c1.io == IO_PWM && !st_ff.c1.dpx
    && (st_ff.cnt < st_ff.compare_a_value)
    |=> st_ff.out == $past(st_ff.c1.oc))
    else $error("duty window not active below compare A");
  chk_cap_pin_idle: assert property (
    st_ff.c1.mode == MODE_CAP |-> !timer_out_pin_a && !timer_out_pin_b)
    else $error("pin driven in capture mode");

  // overflow clearing and register bytes
  chk_overflow_top: assert property (
    p_hit && (st_ff.c0.prd == '0) |-> (&st_ff.cnt))
    else $error("overflow clear away from top count");
  chk_cnt_lo_read: assert property (
    bus_req.rd && bus_req.addr == ADR_CNT_L
    |=> rdata == $past(st_ff.cnt[DAT_W-1:0]))
    else $error("counter low byte wrong");
  chk_cca_hi_pad: assert property (
    bus_req.rd && bus_req.addr == ADR_CCA_H
    |=> rdata[DAT_W-1:HI_W] == HI_PAD)
    else $error("compare high byte pad not zero");
  chk_cca_lo_write: assert property (
    bus_req.wr && bus_req.addr == ADR_CCA_L
    |=> st_ff.compare_a_value[DAT_W-1:0] == $past(bus_req.wdata))
    else $error("compare low byte not stored");

  cov_toggle: cover property (cmp_now && a_hit && st_ff.c1.io == IO_TOGL);
  cov_single_pulse: cover property ((mode == MODE_PWM) && st_ff.c1.io == IO_SINGLE && a_hit);
  cov_pwm_period: cover property ((mode == MODE_PWM) && clr_hit);
  cov_irq_rise: cover property ($rose(irq));
  cov_overflow: cover property (p_hit && st_ff.c0.prd == '0);
endmodule
`default_nettype wire

// File: core/stm_pkg.sv
package stm_pkg;
  localparam int DAT_W    = 8;
  localparam int CNT_W    = 10;
  localparam int PRD_W    = 3;
  localparam int PRD_LSB  = 7;
  localparam int HI_W     = CNT_W - DAT_W;
  localparam int PAD_W    = DAT_W - HI_W;
  localparam int EV_W     = 2;
  localparam int ADR_W    = 4;
  // register byte offsets
  localparam logic [ADR_W-1:0] ADR_CTL0  = 4'h0;
  localparam logic [ADR_W-1:0] ADR_CTL1  = 4'h1;
  localparam logic [ADR_W-1:0] ADR_CNT_L = 4'h2;
  localparam logic [ADR_W-1:0] ADR_CNT_H = 4'h3;
  localparam logic [ADR_W-1:0] ADR_CCA_L = 4'h4;
  localparam logic [ADR_W-1:0] ADR_CCA_H = 4'h5;
  localparam logic [ADR_W-1:0] ADR_STS   = 4'h6;
  localparam logic [ADR_W-1:0] ADR_MSK   = 4'h7;
  localparam logic [PAD_W-1:0]   HI_PAD    = 6'h00;
  localparam logic [PRD_W-1:0]   PRD_ONE   = 3'h1;
  localparam logic [PRD_LSB-1:0] LOW_ALL   = 7'h7F;
  localparam logic [CNT_W-1:0]   CNT_ZERO  = 10'h000;
  localparam logic [CNT_W-1:0]   CNT_ONE   = 10'h001;
  localparam logic [DAT_W-1:0]   DAT_ZERO  = 8'h00;
  localparam int EV_A = 0;
  localparam int EV_P = 1;
  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } stm_mode_t;
  // compare-mode actions; pwm mode reuses codes as inactive/active/pwm/single
  localparam logic [1:0] IO_NONE = 2'b00;
  localparam logic [1:0] IO_LOW  = 2'b01;
  localparam logic [1:0] IO_HIGH = 2'b10;
  localparam logic [1:0] IO_TOGL = 2'b11;
  localparam logic [1:0] IO_INACT  = 2'b00;
  localparam logic [1:0] IO_ACT    = 2'b01;
  localparam logic [1:0] IO_PWM    = 2'b10;
  localparam logic [1:0] IO_SINGLE = 2'b11;
  typedef struct packed {
    logic [DAT_W-PRD_W-2:0] pad;
    logic                   run;
    logic [PRD_W-1:0]       prd;
  } stm_ctl0_t;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] io;
    logic       oc;
    logic       pol;
    logic       dpx;
    logic       cclr;
  } stm_ctl1_t;
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [ADR_W-1:0] addr;
    logic [DAT_W-1:0] wdata;
  } stm_bus_req_t;
  typedef struct packed {
    stm_ctl0_t        c0;
    stm_ctl1_t        c1;
    logic [CNT_W-1:0] compare_a_value;
    logic [CNT_W-1:0] cnt;
    logic             run_prev;
    logic             out;
    logic             sp_act;
    logic             pin;
    logic [EV_W-1:0]  sts;
    logic [EV_W-1:0]  msk;
    logic [DAT_W-1:0] rdata;
    logic             irq;
  } stm_core_t;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic tick;
  } stm_sync_t;
endpackage

// File: core/stm_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module stm_pin_sync import stm_pkg::*; (
  input  wire logic clk,      // core clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic pin_in,   // asynchronous timer clock pin
  output logic      tick      // one-cycle pulse per filtered rising edge
);
  stm_sync_t st_ff;
  stm_sync_t nxt_st;

  // three-stage chain; level accepted once stages two and three agree
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.s1   = pin_in;
    nxt_st.s2   = st_ff.s1;
    nxt_st.s3   = st_ff.s2;
    nxt_st.tick = 1'b0;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.lvl  = st_ff.s3;
      nxt_st.tick = st_ff.s3 & ~st_ff.lvl;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;
endmodule
`default_nettype wire

// File: bench/stm_output_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stm_output_ctrl_tb import stm_pkg::*;;
  logic             clk;
  logic             rst_n;
  logic             tmr_clk_pin;
  logic             pin_a;
  logic             pin_b;
  logic             irq;
  stm_bus_req_t     bus_req;
  logic [DAT_W-1:0] rdata;
  logic [7:0]       m_c1;
  int               fails;
  int               total_checks;
  int               seed;
  int               m_cnt, m_out, m_sp, m_sts, m_msk, m_compare_a_value, m_prd, m_run;

  stm_output_ctrl i_dut (
    .clk             (clk),
    .rst_n           (rst_n),
    .bus_req         (bus_req),
    .rdata           (rdata),
    .tmr_clk_pin     (tmr_clk_pin),
    .timer_out_pin_a (pin_a),
    .timer_out_pin_b (pin_b),
    .irq             (irq)
  );

  // free-running core clock, 8 ns period
  always #4 clk = ~clk;

  // comparison of register read data
  task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // comparison of a pin or interrupt level
  task automatic chk_pin(logic got, logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    bus_req <= '{1'h1, 1'h0, a, v};
    @(posedge clk);
    bus_req <= '0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rchk(logic [3:0] a, int exp);
    logic [7:0] v;
    @(posedge clk);
    bus_req <= '{1'h0, 1'h1, a, 8'h00};
    @(posedge clk);
    bus_req <= '0;
    #1 v = rdata;
    chk_reg(v, exp[7:0]);
  endtask

  task automatic set_c1(logic [7:0] v);
    wr(ADR_CTL1, v);
    m_c1 = v;
    rchk(ADR_CTL1, m_c1);
  endtask

  task automatic set_compare_a_value(int v);
    wr(ADR_CCA_L, v[7:0]);
    wr(ADR_CCA_H, v[15:8]);
    m_compare_a_value = v & 1023;
  endtask

  task automatic set_msk(int v);
    wr(ADR_MSK, v[7:0]);
    m_msk = v;
  endtask

  // run bit write; a rising edge zeroes the count and restarts the output
  task automatic set_run(int run, int prd);
    wr(ADR_CTL0, {4'h0, run[0], prd[2:0]});
    if (run != 0 && m_run == 0) begin
      m_cnt = 0;
      if (m_c1[7:6] == 2'h0) m_out = m_c1[3];
      m_sp = 1;
    end
    m_run = run;
    m_prd = prd;
    rchk(ADR_CTL0, run * 8 + prd);
  endtask

  // one timer clock pulse on the pin, then the model advances
  task automatic tick();
    int a, p, clr;
    @(posedge clk);
    tmr_clk_pin <= 1'h1;
    repeat (4) @(posedge clk);
    tmr_clk_pin <= 1'h0;
    repeat (6) @(posedge clk);
    if (m_run != 0) begin
      a = (m_cnt == m_compare_a_value);
      p = (m_cnt == ((m_prd == 0) ? 1023 : m_prd * 128 - 1));
      m_sts |= a | (p << 1);
      if (m_c1[7:6] == 2'h0 && a != 0 && m_c1[5:4] != 2'h0) begin
        m_out = (m_c1[5:4] == 2'h3) ? !m_out : m_c1[5];
      end
      if (a != 0) m_sp = 0;
      case (m_c1[7:6])
        2'h2: clr = m_c1[1] ? a : p;
        2'h1: clr = p;
        default: clr = m_c1[0] ? a : p;
      endcase
      m_cnt = (clr != 0) ? 0 : (m_cnt + 1) % 1024;
    end
  endtask

  // expected pin level from the model state
  function automatic logic exp_pin();
    logic act;
    case (m_c1[7:6])
      2'h0: return m_out[0] ^ m_c1[2];
      2'h2: begin
        case (m_c1[5:4])
          2'h0: act = 1'h0;
          2'h1: act = 1'h1;
          2'h2: act = m_c1[1] ? ((m_cnt >> 7) < m_prd) : (m_cnt < m_compare_a_value);
          default: act = m_sp[0];
        endcase
        return (act ? m_c1[3] : !m_c1[3]) ^ m_c1[2];
      end
      default: return 1'h0;
    endcase
  endfunction

  // counter bytes, both pins and the interrupt against the model
  task automatic look();
    rchk(ADR_CNT_L, m_cnt);
    rchk(ADR_CNT_H, m_cnt >> 8);
    chk_pin(pin_a, exp_pin());
    chk_pin(pin_b, exp_pin());
    chk_pin(irq, (m_sts & m_msk) != 0);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    end_of_test();
  end

  // main sequence
  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    tmr_clk_pin = 1'h0;
    bus_req = '0;
    m_c1 = 8'h00;
    seed = 34;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    for (int a = 0; a < 9; a++) rchk(a[3:0], 0);
    chk_pin(pin_a, 1'h0);
    chk_pin(pin_b, 1'h0);
    $display("reset test done");
    set_compare_a_value($random(seed));
    rchk(ADR_CCA_L, m_compare_a_value);
    rchk(ADR_CCA_H, m_compare_a_value >> 8);
    wr(ADR_CNT_L, 8'hFF);
    wr(ADR_CNT_H, 8'hFF);
    wr(4'h9, 8'hFF);
    rchk(ADR_CNT_H, 0);
    rchk(4'h9, 0);
    $display("register test done");
    for (int k = 0; k < 16; k++) begin
      set_run(0, 0);
      set_c1({2'h0, k[3:2], k[1], k[0], 2'h0});
      set_compare_a_value(2 + ($random(seed) & 3));
      set_run(1, 0);
      look();
      repeat (7) begin
        tick();
        look();
      end
      set_run(0, 0);
      tick();
      look();
      set_run(1, 0);
      look();
    end
    $display("compare output test done");
    set_run(0, 0);
    set_c1(8'h01);
    set_compare_a_value(5);
    set_run(1, 0);
    repeat (8) begin
      tick();
      look();
    end
    set_run(0, 0);
    set_c1(8'h00);
    set_compare_a_value(1000);
    set_run(1, 1);
    repeat (130) begin
      tick();
      look();
    end
    set_run(0, 0);
    set_run(1, 0);
    repeat (1025) tick();
    look();
    $display("clear source test done");
    rchk(ADR_STS, m_sts);
    set_msk(1);
    look();
    rchk(ADR_MSK, 1);
    set_msk(0);
    look();
    set_msk(3);
    wr(ADR_STS, 8'h01);
    m_sts &= 2;
    look();
    wr(ADR_STS, 8'h02);
    m_sts = 0;
    look();
    rchk(ADR_STS, 0);
    $display("interrupt test done");
    for (int k = 0; k < 32; k++) begin
      set_run(0, 0);
      set_c1({2'h2, k[4:3], k[2], k[1], k[0], 1'h1});
      set_compare_a_value(3);
      set_run(1, 1);
      repeat (6) begin
        tick();
        look();
      end
    end
    $display("pwm test done");
    for (int k = 0; k < 8; k++) begin
      set_run(0, 0);
      set_c1({k[2] ? 2'h3 : 2'h1, 2'h3, k[1], k[0], 2'h1});
      set_compare_a_value(2);
      set_run(1, 0);
      repeat (4) begin
        tick();
        look();
      end
    end
    $display("timer and capture test done");
    end_of_test();
  end
endmodule
`default_nettype wire
